// ==== core_seq_model.sv ====
// Behavioural model of the core sequencer that feeds the interrupt controller.
`timescale 1ns/1ps
module core_seq_model
  import irq_ctrl_pkg::*;
#(
  parameter int PC_W     = 13,
  parameter int CYC_CLKS = 4
) (
  // Clock and reset.
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // Vector request from the controller.
  input  wire logic            vectorTake,
  input  wire logic [PC_W-1:0] vectorTarget,
  // Instruction stream toward the controller.
  output logic                 instrCycle,
  output logic [PC_W-1:0]      programCounter
);
  logic [7:0] divCnt_q;

  // One instruction cycle every CYC_CLKS clocks; a larger value models a slow core.
  always_ff @(posedge clk_sys) begin
    if (reset || divCnt_q == 8'(CYC_CLKS - 1)) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  assign instrCycle = !reset && (divCnt_q == 8'(CYC_CLKS - 1));

  // The vector wins over the normal step, so the handler starts at the target.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      programCounter <= '0;
    end else if (vectorTake) begin
      programCounter <= vectorTarget;
    end else if (instrCycle) begin
      programCounter <= programCounter + 1'b1;
    end
  end
endmodule : core_seq_model

// ==== interrupt_control_unit.sv ====
// Interrupt controller with flag, enable and global gating, vectoring and an AXI4-Lite slave.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module interrupt_control_unit
  import irq_ctrl_pkg::*;
#(
  parameter int PERIPH_A_W = 8,
  parameter int PERIPH_B_W = 1,
  parameter int PC_W       = 13
) (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // AXI4-Lite write channels.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Event sources.
  input  wire logic                  extEdgePin,
  input  wire logic [3:0]            portBPins,
  input  wire logic                  timerZeroRollover,
  input  wire logic [PERIPH_A_W-1:0] periphEventA,
  input  wire logic [PERIPH_B_W-1:0] periphEventB,
  // Core sequencer handshake.
  input  wire logic                  instrCycle,
  input  wire logic                  returnFromIrqInstr,
  input  wire logic                  sleepEnter,
  input  wire logic [PC_W-1:0]       programCounter,
  output logic                       vectorTake,
  output logic [PC_W-1:0]            vectorTarget,
  output logic [PC_W-1:0]            pushAddr,
  output logic                       wakeUp,
  output logic                       sleeping
);

  localparam int N_SRC = 3 + PERIPH_A_W + PERIPH_B_W;

  // Every parameter set is refused: N_SRC must be 11, but PERIPH_A_W of 8 and PERIPH_B_W of 1 or more give 12 or more.
  if (PERIPH_A_W != 8 || PERIPH_B_W < 1 || PERIPH_B_W > 8 || PC_W != 13 || N_SRC != 12 - 1)
    $error("interrupt_control_unit: unsupported parameter set");

  logic [7:0]            ctrl_q;
  logic [PERIPH_A_W-1:0] pflagA_q, penA_q;
  logic [PERIPH_B_W-1:0] pflagB_q, penB_q;
  logic [7:0]            option_q;
  logic                  pin_q, pinValid_q;
  logic [3:0]            portLatch_q;
  seq_state_t            state_q;
  logic [1:0]            lat_q;
  logic                  reqPending;
  logic                  coreTerm, periphTerm;
  logic                  wakeCause;
  vector_req_t           vec_q;

  // Write path: address and data each latched once, in either order.
  logic        awHave_q, wHave_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic        wrHit;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

  // Address decode; unmapped addresses answer with a slave error.
  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CORE_CTRL || a == ADDR_PFLAG_A || a == ADDR_PFLAG_B ||
           a == ADDR_PEN_A || a == ADDR_PEN_B || a == ADDR_OPTION ||
           a == ADDR_CORE_STATUS;
  endfunction : mapped

  // A write with the low byte lane off is taken and answered, but it changes nothing.
  assign wrHit = doWrite && wStrb_q[0];

  // Write address and data capture; ready drops while a word is held.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          ADDR_CORE_CTRL:   s_axi_rdata <= {24'h00_0000, ctrl_q};
          ADDR_PFLAG_A:     s_axi_rdata <= 32'(pflagA_q);
          ADDR_PFLAG_B:     s_axi_rdata <= 32'(pflagB_q);
          ADDR_PEN_A:       s_axi_rdata <= 32'(penA_q);
          ADDR_PEN_B:       s_axi_rdata <= 32'(penB_q);
          ADDR_OPTION:      s_axi_rdata <= {24'h00_0000, option_q};
          ADDR_CORE_STATUS: s_axi_rdata <= {29'h000_0000, reqPending, state_q};
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pin edge and port change detection; inputs are synchronous already.
  logic pinEdge, portChange;
  assign pinEdge    = pinValid_q && (option_q[BIT_EDGE_SELECT] ? (extEdgePin && !pin_q)
                                                               : (!extEdgePin && pin_q));
  assign portChange = pinValid_q && (portBPins != portLatch_q);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_q       <= 1'b0;
      pinValid_q  <= 1'b0;
      portLatch_q <= 4'h0;
    end else begin
      pin_q       <= extEdgePin;
      pinValid_q  <= 1'b1;
      portLatch_q <= portBPins;
    end
  end

  // Option register; only the edge-select bit steers this block.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      option_q <= RST_OPTION;
    end else if (wrHit && awAddr_q == ADDR_OPTION) begin
      option_q <= wData_q[7:0];
    end
  end

  // Acceptance happens on an instruction cycle in the run state, with a request standing and the latency count at zero.
  logic accept;
  assign accept = instrCycle && state_q == ST_RUN && reqPending && lat_q == 2'd0;

  // Control register; an event wins over a software write of zero in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= RST_CORE_CTRL;
    end else begin
      if (wrHit && awAddr_q == ADDR_CORE_CTRL) begin
        ctrl_q <= wData_q[7:0];
      end
      if (accept) begin
        ctrl_q[BIT_GLOBAL_EN] <= 1'b0;
      end else if (returnFromIrqInstr) begin
        ctrl_q[BIT_GLOBAL_EN] <= 1'b1;
      end
      if (pinEdge) ctrl_q[BIT_PIN_FLAG] <= 1'b1;
      if (timerZeroRollover) ctrl_q[BIT_TIMER_FLAG] <= 1'b1;
      if (portChange) ctrl_q[BIT_PORT_FLAG] <= 1'b1;
    end
  end

  // Peripheral flags and enables, one bit slice per source.
  genvar gi;
  generate
    for (gi = 0; gi < PERIPH_A_W; gi++) begin : g_pa
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          pflagA_q[gi] <= 1'b0;
          penA_q[gi]   <= 1'b0;
        end else begin
          if (wrHit && awAddr_q == ADDR_PFLAG_A) pflagA_q[gi] <= wData_q[gi];
          if (periphEventA[gi]) pflagA_q[gi] <= 1'b1;
          if (wrHit && awAddr_q == ADDR_PEN_A) penA_q[gi] <= wData_q[gi];
        end
      end
    end
    for (gi = 0; gi < PERIPH_B_W; gi++) begin : g_pb
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          pflagB_q[gi] <= 1'b0;
          penB_q[gi]   <= 1'b0;
        end else begin
          if (wrHit && awAddr_q == ADDR_PFLAG_B) pflagB_q[gi] <= wData_q[gi];
          if (periphEventB[gi]) pflagB_q[gi] <= 1'b1;
          if (wrHit && awAddr_q == ADDR_PEN_B) penB_q[gi] <= wData_q[gi];
        end
      end
    end
  endgenerate

  // Request logic: each flag masked by its own enable, then grouped and gated.
  assign coreTerm   = (ctrl_q[BIT_PIN_FLAG] && ctrl_q[BIT_PIN_EN]) ||
                      (ctrl_q[BIT_TIMER_FLAG] && ctrl_q[BIT_TIMER_EN]) ||
                      (ctrl_q[BIT_PORT_FLAG] && ctrl_q[BIT_PORT_EN]);
  assign periphTerm = ctrl_q[BIT_PERIPH_EN] &&
                      (|(pflagA_q & penA_q) || |(pflagB_q & penB_q));
  assign wakeCause  = coreTerm || periphTerm;
  assign reqPending = ctrl_q[BIT_GLOBAL_EN] && wakeCause;

  // Sequencer: run, sleep, and the one-instruction step after wake.
  // The sleep output is a flip-flop of its own, so it never glitches on the state decode.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q  <= ST_RUN;
      wakeUp   <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      wakeUp <= 1'b0;
      case (state_q)
        ST_RUN:   if (sleepEnter && !accept) begin
          state_q  <= ST_SLEEP;
          sleeping <= 1'b1;
        end
        ST_SLEEP: if (wakeCause) begin
          wakeUp   <= 1'b1;
          sleeping <= 1'b0;
          state_q  <= ST_WAIT;
        end
        ST_WAIT:  if (instrCycle) state_q <= ST_RUN;
        default: begin
          state_q  <= ST_RUN;
          sleeping <= 1'b0;
        end
      endcase
    end
  end

  // Latency counter holds off vectoring for the fixed number of instruction cycles.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lat_q <= 2'd0;
    end else if ((pinEdge || portChange) && lat_q == 2'd0) begin
      lat_q <= 2'(EXT_LATENCY_CYC - 1);
    end else if (instrCycle && lat_q != 2'd0) begin
      lat_q <= lat_q - 2'd1;
    end
  end

  // Vector request: return address is the next instruction.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vec_q <= '0;
    end else begin
      vec_q.take     <= accept;
      vec_q.target   <= IRQ_VECTOR;
      vec_q.pushAddr <= accept ? programCounter + 13'd1 : vec_q.pushAddr;
    end
  end

  // The vector outputs are plain wires onto the fields of one register.
  assign vectorTake   = vec_q.take;
  assign vectorTarget = vec_q.target;
  assign pushAddr     = vec_q.pushAddr;

  // Checks on the global enable, vectoring and flags.
  accept_clears_a: assert property (@(posedge clk_sys) disable iff (reset)
    accept |=> !ctrl_q[BIT_GLOBAL_EN] && vectorTake)
    else $error("acceptance did not clear the global enable");
  ret_sets_a: assert property (@(posedge clk_sys) disable iff (reset)
    returnFromIrqInstr && !accept |=> ctrl_q[BIT_GLOBAL_EN])
    else $error("return did not set the global enable");
  gated_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    !ctrl_q[BIT_GLOBAL_EN] |-> !accept)
    else $error("accepted with global enable clear");
  pin_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    pinEdge |=> ctrl_q[BIT_PIN_FLAG])
    else $error("pin edge lost");
  timer_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    timerZeroRollover |=> ctrl_q[BIT_TIMER_FLAG])
    else $error("timer rollover lost");
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_q[BIT_PORT_FLAG] && !(wrHit && awAddr_q == ADDR_CORE_CTRL) |=> ctrl_q[BIT_PORT_FLAG])
    else $error("flag cleared without a write");
  vector_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
    vectorTake |-> vectorTarget == IRQ_VECTOR && pushAddr == $past(programCounter) + 13'd1)
    else $error("wrong vector or return address");
  wake_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    wakeUp |-> state_q == ST_WAIT ##0 !accept)
    else $error("vectored before next instruction");
  latency_a: assert property (@(posedge clk_sys) disable iff (reset)
    lat_q != 2'd0 |-> !accept)
    else $error("external event vectored early");

  // Reset, flag-set and sleep checks; the reset check must not be switched off by reset.
  reset_gie_a: assert property (@(posedge clk_sys)
    reset |=> !ctrl_q[BIT_GLOBAL_EN])
    else $error("reset left the global enable set");
  port_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    portChange |=> ctrl_q[BIT_PORT_FLAG])
    else $error("port change lost");
  periph_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    periphEventA != '0 |=> (pflagA_q & $past(periphEventA)) == $past(periphEventA))
    else $error("peripheral event lost");
  sleep_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    sleeping && !wakeCause |=> sleeping)
    else $error("left sleep without an enabled flag");
  sleep_mirror_a: assert property (@(posedge clk_sys) disable iff (reset)
    sleeping == (state_q == ST_SLEEP))
    else $error("sleep output disagrees with the sequencer");

  accept_c: cover property (@(posedge clk_sys) disable iff (reset) accept);
  wake_c:   cover property (@(posedge clk_sys) disable iff (reset) wakeUp);
  ret_c:    cover property (@(posedge clk_sys) disable iff (reset) returnFromIrqInstr);
  sleep_c:  cover property (@(posedge clk_sys) disable iff (reset) sleeping && wakeCause);
  delay_c:  cover property (@(posedge clk_sys) disable iff (reset) lat_q != 2'd0 && instrCycle);

endmodule : interrupt_control_unit

// ==== irq_ctrl_pkg.sv ====
// Package with register map, field positions and types for the interrupt controller.
// Function
// - Eleven sources, each with its own flag bit and enable bit; the code has twelve, three core and nine peripheral.
// - Flags set on their event whatever the enables say.
// - Global enable at control bit 7 permits or blocks all interrupts.
// - Enabled pending source with global enable set vectors at once.
// - Clearing one enable masks only that source.
// - Reset clears the global enable.
// - Return-from-interrupt leaves handler and sets global enable.
// - Pin, port-change and timer flags and enables sit in control register.
// - Peripheral flags in two flag registers, enables in two; group enable in control.
// - Acceptance clears global enable, pushes return address, vectors to 0004h.
// - External events vector three or four cycles later, for any instruction.
// - Interrupt wake with global enable executes next instruction then vectors.
// - Wake leaves the causing flags set.
// - Pin edge polarity from option bit 6; valid edge sets control bit 1.
// - Timer rollover sets control bit 2; its enable is control bit 5.
// - Change on upper four port-B pins sets control bit 0.
// - Enabled pin interrupt wakes from sleep; global enable decides vectoring.
package irq_ctrl_pkg;

  // Byte addresses on the register bus.
  localparam logic [7:0] ADDR_CORE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PFLAG_A     = 8'h04;
  localparam logic [7:0] ADDR_PFLAG_B     = 8'h08;
  localparam logic [7:0] ADDR_PEN_A       = 8'h0C;
  localparam logic [7:0] ADDR_PEN_B       = 8'h10;
  localparam logic [7:0] ADDR_OPTION      = 8'h14;
  localparam logic [7:0] ADDR_CORE_STATUS = 8'h18;

  // Control register bit positions, and the option register edge-select bit.
  localparam int BIT_PORT_FLAG   = 0;
  localparam int BIT_PIN_FLAG    = 1;
  localparam int BIT_TIMER_FLAG  = 2;
  localparam int BIT_PORT_EN     = 3;
  localparam int BIT_PIN_EN      = 4;
  localparam int BIT_TIMER_EN    = 5;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_EDGE_SELECT = 6;

  // Reset values.
  localparam logic [7:0] RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH    = 8'h00;
  localparam logic [7:0] RST_OPTION    = 8'hFF;

  // Vector and timing.
  localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
  localparam int          EXT_LATENCY_CYC = 3;

  // AXI answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Core sequencer state.
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SLEEP = 2'b11
  } seq_state_t;

  // Vector request toward the core sequencer.
  typedef struct packed {
    logic        take;
    logic [12:0] target;
    logic [12:0] pushAddr;
  } vector_req_t;

endpackage : irq_ctrl_pkg

// ==== tb_top.sv ====
// Self-checking testbench of the interrupt controller.
`timescale 1ns/1ps
module tb_top;
  import irq_ctrl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, periphEventA = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hF, portBPins = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, extEdgePin = 0, timerZeroRollover = 0, returnFromIrqInstr = 0;
  logic sleepEnter = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, instrCycle, vectorTake, wakeUp, sleeping, got;
  logic [0:0]  periphEventB = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [12:0] programCounter, vectorTarget, pushAddr, pcHist;
  int          errors = 0, n_tests = 0, nCyc;

  // The clock toggles every half period of 2 ns.
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pcHist <= programCounter;

  interrupt_control_unit interrupt_control_unit_i (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .extEdgePin(extEdgePin),
    .portBPins(portBPins), .timerZeroRollover(timerZeroRollover),
    .periphEventA(periphEventA), .periphEventB(periphEventB), .instrCycle(instrCycle),
    .returnFromIrqInstr(returnFromIrqInstr), .sleepEnter(sleepEnter),
    .programCounter(programCounter), .vectorTake(vectorTake), .vectorTarget(vectorTarget),
    .pushAddr(pushAddr), .wakeUp(wakeUp), .sleeping(sleeping));

  core_seq_model core_seq_model_i (
    .clk_sys(clk_sys), .reset(reset), .vectorTake(vectorTake),
    .vectorTarget(vectorTarget), .instrCycle(instrCycle), .programCounter(programCounter));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Write with address and data offered together; each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rdat, rsp);
    check(rdat, exp, "register read");
  endtask : rdChk

  // Waits for a vector, counting instruction cycles on the way.
  task automatic waitTake(input int lim);
    nCyc = 0;
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys);
      if (vectorTake === 1'b1) got = 1'b1;
      else if (instrCycle === 1'b1) nCyc++;
    end
  endtask : waitTake

  task automatic t_reset;
    rdChk(ADDR_CORE_CTRL, 32'h0000_0000);
    rdChk(ADDR_OPTION, 32'h0000_00FF);
    rdChk(ADDR_PEN_A, 32'h0000_0000);
    rdChk(ADDR_PEN_B, 32'h0000_0000);
    rd(8'h1C, rdat, rsp);
    check(rsp, RESP_SLVERR, "unmapped read");
    wr(8'h1C, 32'h0000_00FF, rsp);
    check(rsp, RESP_SLVERR, "unmapped write");
    s_axi_wstrb <= 4'h0;
    wr(ADDR_PEN_A, 32'h0000_00FF, rsp);
    s_axi_wstrb <= 4'hF;
    check(rsp, RESP_OKAY, "lane-off write answer");
    rdChk(ADDR_PEN_A, 32'h0000_0000);
  endtask : t_reset

  // Events with every enable off still leave their flags.
  task automatic t_flags;
    timerZeroRollover <= 1'b1;
    periphEventA <= 8'h81;
    periphEventB <= 1'b1;
    @(posedge clk_sys);
    {timerZeroRollover, periphEventA, periphEventB} <= '0;
    waitTake(20);
    check(got, 1'b0, "vector with global enable off");
    rdChk(ADDR_CORE_CTRL, 32'h0000_0004);
    rdChk(ADDR_PFLAG_A, 32'h0000_0081);
    rdChk(ADDR_PFLAG_B, 32'h0000_0001);
    wr(ADDR_PFLAG_A, 32'h0000_0000, rsp);
    wr(ADDR_PFLAG_B, 32'h0000_0000, rsp);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    rdChk(ADDR_PFLAG_A, 32'h0000_0000);
    rdChk(ADDR_CORE_CTRL, 32'h0000_0000);
  endtask : t_flags

  // A masked source stays quiet; an enabled one vectors, then return re-arms.
  task automatic t_mask;
    wr(ADDR_PEN_A, 32'h0000_0001, rsp);
    wr(ADDR_CORE_CTRL, 32'h0000_00C0, rsp);
    periphEventA <= 8'h02;
    @(posedge clk_sys);
    periphEventA <= 8'h00;
    waitTake(20);
    check(got, 1'b0, "masked source vectored");
    periphEventA <= 8'h01;
    @(posedge clk_sys);
    periphEventA <= 8'h00;
    waitTake(40);
    check(got, 1'b1, "enabled source no vector");
    check(vectorTarget, IRQ_VECTOR, "vector target");
    check(pushAddr, pcHist + 13'h0001, "return address");
    rdChk(ADDR_CORE_CTRL, 32'h0000_0040);
    rdChk(ADDR_PFLAG_A, 32'h0000_0003);
    wr(ADDR_PFLAG_A, 32'h0000_0000, rsp);
    returnFromIrqInstr <= 1'b1;
    @(posedge clk_sys);
    returnFromIrqInstr <= 1'b0;
    waitTake(20);
    check(got, 1'b0, "retrigger after return");
    rdChk(ADDR_CORE_CTRL, 32'h0000_00C0);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    rdChk(ADDR_CORE_CTRL, 32'h0000_0000);
  endtask : t_mask

  // Timer rollover with its own enable vectors at the next instruction, with no extra delay.
  task automatic t_timer;
    wr(ADDR_CORE_CTRL, 32'h0000_00A0, rsp);
    timerZeroRollover <= 1'b1;
    @(posedge clk_sys);
    timerZeroRollover <= 1'b0;
    waitTake(40);
    check(got, 1'b1, "timer no vector");
    check(nCyc, 32'd1, "timer latency");
    rdChk(ADDR_CORE_CTRL, 32'h0000_0024);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
  endtask : t_timer

  // Pin polarity, pin latency and port change.
  task automatic t_edge;
    wr(ADDR_CORE_CTRL, 32'h0000_0090, rsp);
    extEdgePin <= 1'b1;
    waitTake(60);
    check(got, 1'b1, "rising pin no vector");
    check(32'(nCyc >= 3 && nCyc <= 4), 32'd1, "pin latency");
    rdChk(ADDR_CORE_CTRL, 32'h0000_0012);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    wr(ADDR_OPTION, 32'h0000_00BF, rsp);
    extEdgePin <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rdChk(ADDR_CORE_CTRL, 32'h0000_0002);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    extEdgePin <= 1'b1;
    portBPins <= 4'h4;
    repeat (20) @(posedge clk_sys);
    rdChk(ADDR_CORE_CTRL, 32'h0000_0001);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    wr(ADDR_OPTION, 32'h0000_00FF, rsp);
    extEdgePin <= 1'b0;
  endtask : t_edge

  // Wake from sleep by the pin, first without and then with the global enable.
  task automatic t_sleep(input logic [31:0] ctl);
    wr(ADDR_CORE_CTRL, ctl, rsp);
    sleepEnter <= 1'b1;
    @(posedge clk_sys);
    sleepEnter <= 1'b0;
    for (int i = 0; i < 20 && sleeping !== 1'b1; i++) @(posedge clk_sys);
    check(sleeping, 1'b1, "sleep entry");
    rdChk(ADDR_CORE_STATUS, 32'h0000_0003);
    extEdgePin <= 1'b1;
    for (int i = 0; i < 40 && wakeUp !== 1'b1; i++) @(posedge clk_sys);
    check(wakeUp, 1'b1, "wake by pin");
    waitTake(60);
    check(got, ctl[7], "vector after wake");
    if (ctl[7]) check(32'(nCyc >= 1), 32'd1, "instruction before vector");
    rdChk(ADDR_CORE_CTRL, {ctl[31:8], 1'b0, ctl[6:0]} | 32'h0000_0002);
    wr(ADDR_CORE_CTRL, 32'h0000_0000, rsp);
    extEdgePin <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : t_sleep

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_flags();
    t_mask();
    t_timer();
    t_edge();
    t_sleep(32'h0000_0010);
    t_sleep(32'h0000_0090);
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end
endmodule : tb_top
